// ===== rtl/adcot_top.sv
// Purpose: overtemperature compare and indexed parameter access registers
// Assumes: temperature samples arrive from conversion logic on SYS_CLK
// Notes:   reads answer one cycle after the strobe, never wait states
`timescale 1ns/100ps
`default_nettype none
module adcot_top (
    input  wire logic                        SYS_CLK,
    input  wire logic                        RST_N,
    input  wire logic [adcot_pkg::ADCOT_AW-1:0] ADDR,
    input  wire logic [adcot_pkg::ADCOT_DW-1:0] WDATA,
    input  wire logic                        WR,
    input  wire logic                        RD,
    output var  logic [adcot_pkg::ADCOT_DW-1:0] RDATA,
    input  wire logic                        TEMP_VALID,
    input  wire logic [7:0]                  TEMP_DATA,
    output var  logic                        OVERTEMP_OUT,
    output var  logic                        IRQ
);
    import adcot_pkg::*;

    typedef struct packed {
        logic [15:0] rdata;
        logic [7:0]  limit;
        logic [7:0]  index;
        logic [7:0]  cfg;
        logic [7:0]  mask;
        logic [7:0]  stat;
        logic [7:0]  temp;
        logic        temp_seen;
        logic        hot;
        logic        irq;
    } adcot_regs_t;

    adcot_regs_t r_q;
    adcot_regs_t r_d;

    adcot_par_if par ();

    adcot_par_store #(
        .DEPTH (256)
    ) adcot_par_store_inst (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .par   (par)
    );

    // signed compare of a sample against the limit
    function automatic logic adcot_above(input logic [7:0] t,
                                         input logic [7:0] lim);
        adcot_above = $signed(t) > $signed(lim);
    endfunction : adcot_above

    logic hit_now;
    logic [7:0] lim_eff;

    // window traffic goes straight to the store
    assign par.idx   = r_q.index;
    assign par.wdata = WDATA;
    assign par.we    = WR && (ADDR == ADCOT_OFS_WINDOW);

    // a new limit applies to OVERTEMP_OUT in its write cycle; hit_now and the status bits still use the old limit
    assign lim_eff = (WR && ADDR == ADCOT_OFS_LIMIT) ? WDATA[7:0] : r_q.limit;
    assign hit_now = TEMP_VALID && adcot_above(TEMP_DATA, r_q.limit);

    // register writes, reads, event capture
    always_comb begin
        r_d = r_q;
        if (WR) begin
            case (ADDR)
                ADCOT_OFS_CFG:   r_d.cfg   = WDATA[7:0];
                ADCOT_OFS_MASK:  r_d.mask  = WDATA[7:0];
                ADCOT_OFS_LIMIT: r_d.limit = WDATA[7:0];
                ADCOT_OFS_INDEX: r_d.index = WDATA[7:0];
                default: ;
            endcase
        end
        r_d.rdata = '0;
        if (RD) begin
            case (ADDR)
                ADCOT_OFS_CFG: begin
                    r_d.rdata = {8'h00, r_q.cfg};
                    r_d.rdata[ADCOT_CFG_LOCK_BIT] = par.locked;
                end
                ADCOT_OFS_STAT: begin
                    r_d.rdata = {8'h00, r_q.stat};
                    r_d.stat  = '0; // read clears
                end
                ADCOT_OFS_MASK:   r_d.rdata = {8'h00, r_q.mask};
                ADCOT_OFS_LIMIT:  r_d.rdata = {8'h00, r_q.limit};
                ADCOT_OFS_INDEX:  r_d.rdata = {8'h00, r_q.index};
                ADCOT_OFS_WINDOW: r_d.rdata = par.rdata;
                default:          r_d.rdata = '0; // unmapped reads zero
            endcase
        end
        // latest local sample kept so a limit change re-evaluates
        if (TEMP_VALID) begin
            r_d.temp      = TEMP_DATA;
            r_d.temp_seen = 1'b1;
        end
        // set beats a same-cycle read clear
        if (hit_now) begin
            r_d.stat[ADCOT_STAT_OT_BIT] = 1'b1;
        end
        r_d.stat[ADCOT_STAT_HOT_BIT] = r_d.stat[ADCOT_STAT_HOT_BIT] | hit_now;
        r_d.hot = r_d.temp_seen && adcot_above(r_d.temp, lim_eff);
        r_d.irq = r_d.cfg[ADCOT_CFG_IRQEN_BIT]
                  && |(r_d.stat & r_d.mask & 8'h03);
        r_d.cfg[7:2] = '0; // reserved bits read zero
        r_d.cfg[ADCOT_CFG_LOCK_BIT] = 1'b0;
    end

    // state register
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            r_q       <= '0;
            r_q.limit <= ADCOT_LIMIT_RST;
            r_q.index <= ADCOT_INDEX_RST;
            r_q.cfg   <= ADCOT_CFG_RST;
            r_q.mask  <= ADCOT_MASK_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from flops
    assign RDATA        = r_q.rdata;
    assign OVERTEMP_OUT = r_q.hot;
    assign IRQ          = r_q.irq;

endmodule : adcot_top
`default_nettype wire

// ===== rtl/adcot_pkg.sv
// Purpose: constants shared by the overtemperature and parameter access block
// Assumes: 16-bit register port, byte offsets as printed in the memory map
// Notes:   all offsets, field positions and reset values live here
package adcot_pkg;

    localparam int ADCOT_AW = 16;
    localparam int ADCOT_DW = 16;

    // register byte offsets
    localparam logic [15:0] ADCOT_OFS_CFG    = 16'hFF20;
    localparam logic [15:0] ADCOT_OFS_STAT   = 16'hFF22;
    localparam logic [15:0] ADCOT_OFS_MASK   = 16'hFF24;
    localparam logic [15:0] ADCOT_OFS_LIMIT  = 16'hFF28;
    localparam logic [15:0] ADCOT_OFS_INDEX  = 16'hFF2A;
    localparam logic [15:0] ADCOT_OFS_WINDOW = 16'hFF2C;

    // field positions
    localparam int ADCOT_CFG_IRQEN_BIT = 0;
    localparam int ADCOT_CFG_LOCK_BIT  = 1;
    localparam int ADCOT_STAT_OT_BIT   = 0;
    localparam int ADCOT_STAT_HOT_BIT  = 1;

    // reset values
    localparam logic [7:0]  ADCOT_LIMIT_RST = 8'h7F;
    localparam logic [7:0]  ADCOT_INDEX_RST = 8'h00;
    localparam logic [7:0]  ADCOT_CFG_RST   = 8'h00;
    localparam logic [7:0]  ADCOT_MASK_RST  = 8'h00;
    localparam logic [15:0] ADCOT_PAR_RST   = 16'h0000;

    // lock key: this value written while the index is the lock index
    localparam logic [7:0]  ADCOT_LOCK_IDX  = 8'h00;
    localparam logic [15:0] ADCOT_LOCK_KEY  = 16'h0001;

endpackage : adcot_pkg

// ===== rtl/adcot_par_if.sv
// Purpose: carrier between the register front end and the parameter store
// Assumes: single clock, store read path is combinational
// Notes:   front end drives index and write, store answers data and lock
`timescale 1ns/100ps
`default_nettype none
interface adcot_par_if;
    logic [7:0]  idx;
    logic [15:0] wdata;
    logic        we;
    logic [15:0] rdata;
    logic        locked;

    modport front (output idx, output wdata, output we,
                   input rdata, input locked);
    modport store (input idx, input wdata, input we,
                   output rdata, output locked);
endinterface : adcot_par_if
`default_nettype wire

// ===== rtl/adcot_par_store.sv
// Purpose: hidden converter parameter registers behind the index/window
// Assumes: one write strobe per cycle from the front end
// Notes:   lock is sticky until reset; no way to unlock in software
`timescale 1ns/100ps
`default_nettype none
module adcot_par_store #(
    parameter int DEPTH = 256
) (
    input  wire logic      clk,
    input  wire logic      rst_n,
    adcot_par_if.store     par
);
    import adcot_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][15:0] mem;
        logic                   lock;
    } adcot_store_t;

    adcot_store_t st_q;
    adcot_store_t st_d;

    // write path: locked writes vanish without any error indication
    always_comb begin
        st_d = st_q;
        if (par.we && !st_q.lock) begin
            st_d.mem[par.idx] = par.wdata;
            if (par.idx == ADCOT_LOCK_IDX && par.wdata == ADCOT_LOCK_KEY) begin
                st_d.lock = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // reads stay open while locked
    assign par.rdata  = st_q.mem[par.idx];
    assign par.locked = st_q.lock;

endmodule : adcot_par_store
`default_nettype wire

// ===== sim/adcot_top_assertions.sv
// Purpose: port checks of adcot_top
// Assumes: limit shadowed from bus writes
// Notes:   samples beside a write are skipped
`timescale 1ns/100ps
`default_nettype none
module adcot_top_checker (
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic [15:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        TEMP_VALID,
    input wire logic [7:0]  TEMP_DATA,
    input wire logic        OVERTEMP_OUT,
    input wire logic        IRQ
);
    logic [7:0] lim_q;
    // shadow limit, so no internal probe is needed
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) lim_q <= 8'h7F;
        else if (WR && ADDR == 16'hFF28) lim_q <= WDATA[7:0];
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence clean_s; TEMP_VALID && !WR; endsequence
    sequence hot_s; clean_s ##0 $signed(TEMP_DATA) > $signed(lim_q);
    endsequence
    sequence cool_s; clean_s ##0 $signed(TEMP_DATA) <= $signed(lim_q);
    endsequence
    ot_hot_a: assert property (hot_s |=> OVERTEMP_OUT)
        else $error("overtemp missing");
    ot_cool_a: assert property (cool_s |=> !OVERTEMP_OUT)
        else $error("overtemp false");
    ot_cause_a: assert property ($rose(OVERTEMP_OUT) |->
        $past(TEMP_VALID) || $past(WR)) else $error("overtemp no cause");
    irq_cause_a: assert property ($rose(IRQ) |->
        $past(TEMP_VALID) || $past(WR)) else $error("irq no cause");
    irq_clear_a: assert property (RD && ADDR == 16'hFF22 &&
        !TEMP_VALID |-> ##[1:2] !IRQ) else $error("irq stuck");
    rd_idle_a: assert property (!RD |=> RDATA == 16'h0000)
        else $error("rdata not idle");
    rd_unmap_a: assert property (RD && ADDR == 16'hFF00 |=>
        RDATA == 16'h0000) else $error("unmapped read");
    lim_read_a: assert property (RD && ADDR == 16'hFF28 |=>
        RDATA == {8'h00, lim_q}) else $error("limit read");
endmodule : adcot_top_checker
bind adcot_top adcot_top_checker adcot_top_checker_inst (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .TEMP_VALID(TEMP_VALID),
    .TEMP_DATA(TEMP_DATA), .OVERTEMP_OUT(OVERTEMP_OUT), .IRQ(IRQ));
`default_nettype wire

// ===== sim/test_adcot_top.sv
// Purpose: directed bench for adcot_top
// Assumes: one-cycle read latency, no waits
// Notes:   fixed-length accesses only
`timescale 1ns/100ps
`default_nettype none
module test_adcot_top;
    logic        clk, rst_n, wr, rd, tv, ot, irq;
    logic [15:0] addr, wdata, rdata;
    logic [7:0]  tdat;
    int          n_errors, checks;
    adcot_top adcot_top_inst (.SYS_CLK(clk), .RST_N(rst_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .TEMP_VALID(tv), .TEMP_DATA(tdat), .OVERTEMP_OUT(ot),
        .IRQ(irq));
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cmp(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic wr_reg(input logic [15:0] a, d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp("rdata", e, rdata);
    endtask : rd_reg
    task automatic smp(input logic [7:0] t, input logic e);
        @(posedge clk);
        tv <= 1'b1;
        tdat <= t;
        @(posedge clk);
        tv <= 1'b0;
        #1;
        cmp("ot", {15'h0, e}, {15'h0, ot});
    endtask : smp
    // an extra edge so a lag of either kind has landed
    task automatic outs(input logic eo, ei);
        @(posedge clk);
        #1;
        cmp("ot", {15'h0, eo}, {15'h0, ot});
        cmp("irq", {15'h0, ei}, {15'h0, irq});
    endtask : outs
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        {rst_n, wr, rd, tv} = 4'h0;
        {addr, wdata, tdat} = 40'h0;
        n_errors = 0;
        checks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(16'hFF28, 16'h007F);
        rd_reg(16'hFF2A, 16'h0000);
        rd_reg(16'hFF00, 16'h0000);
        smp(8'h7F, 1'b0);
        wr_reg(16'hFF28, 16'h000A);
        rd_reg(16'hFF28, 16'h000A);
        smp(8'h0A, 1'b0);
        smp(8'h0B, 1'b1);
        wr_reg(16'hFF24, 16'h0003);
        outs(1'b1, 1'b0);
        wr_reg(16'hFF20, 16'h0001);
        outs(1'b1, 1'b1);
        rd_reg(16'hFF22, 16'h0003);
        outs(1'b1, 1'b0);
        wr_reg(16'hFF28, 16'h00F6);
        smp(8'h80, 1'b0);
        smp(8'hFB, 1'b1);
        wr_reg(16'hFF28, 16'h007F);
        outs(1'b0, 1'b1);
        wr_reg(16'hFF20, 16'h0000);
        outs(1'b0, 1'b0);
        // two words, then read both back through the window
        wr_reg(16'hFF2A, 16'h0005);
        wr_reg(16'hFF2C, 16'h1234);
        wr_reg(16'hFF2A, 16'h00FF);
        wr_reg(16'hFF2C, 16'h5678);
        rd_reg(16'hFF2C, 16'h5678);
        wr_reg(16'hFF2A, 16'h0005);
        rd_reg(16'hFF2A, 16'h0005);
        rd_reg(16'hFF2C, 16'h1234);
        wr_reg(16'hFF2A, 16'h0000);
        wr_reg(16'hFF2C, 16'h0001);
        rd_reg(16'hFF20, 16'h0002);
        wr_reg(16'hFF2A, 16'h0005);
        wr_reg(16'hFF2C, 16'hABCD);
        rd_reg(16'hFF2C, 16'h1234);
        // lock lasts only until the next reset
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(16'hFF20, 16'h0000);
        report_and_stop();
    end
endmodule : test_adcot_top
`default_nettype wire
